/* File: hw/dpc_pkg.sv */
// Purpose: Shared constants and types for the DAC output power-on control block
// Assumes: 125 MHz system clock, four channels of 16-bit data
// Notes: Trim levels are in eighths of a data LSB, offset-binary at the core
package dpc_pkg;
   localparam int NUM_CH = 4;
   localparam int CODE_W = 16;
   localparam int FRAC_W = 3;
   localparam int LEVEL_W = CODE_W + FRAC_W;
   localparam int OFS_W = 8;
   localparam int FG_W = 6;
   localparam int CG_W = 2;
   localparam int GND_W = 8;
   localparam int REG_W = 3;
   localparam int ADDR_W = 3;
   localparam int ADDR_BCAST_BIT = 2;
   localparam int GAIN_SHIFT = 13;

   // Register select codes of a completed serial frame
   localparam logic [REG_W-1:0] REG_DATA = 3'h2;
   localparam logic [REG_W-1:0] REG_COARSE = 3'h3;
   localparam logic [REG_W-1:0] REG_FINE = 3'h4;
   localparam logic [REG_W-1:0] REG_OFFSET = 3'h5;

   // Coarse range codes
   localparam logic [CG_W-1:0] CG_4096 = 2'h0;
   localparam logic [CG_W-1:0] CG_4201 = 2'h1;
   localparam logic [CG_W-1:0] CG_4311 = 2'h2;
   localparam logic [CG_W-1:0] CG_ILLEGAL = 2'h3;

   // Reset values
   localparam logic [CODE_W-1:0] ZERO_CODE = 16'h0000;
   localparam logic [CG_W-1:0] CG_RESET = 2'h0;
   localparam logic [FG_W-1:0] FG_RESET = 6'h00;
   localparam logic [OFS_W-1:0] OFS_RESET = 8'h00;

   // Supply settling before the straps are sampled
   localparam int CLK_MHZ = 125;
   localparam int STABLE_TIME_NS = 1000;
   localparam int STABLE_CYCLES = (STABLE_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int STABLE_CNT_W = $clog2(STABLE_CYCLES + 1);

   typedef enum logic [1:0] {ST_POWERUP, ST_WAIT_WRITE, ST_ACTIVE} dpc_state_t;
endpackage

/* File: hw/dpc_trim_if.sv */
// Purpose: Carries one channel's code and trims to the trim datapath and back
// Assumes: All signals on the system clock
// Notes: Level is offset-binary in eighths of an LSB
`timescale 1ns/1ns
`default_nettype none
interface dpc_trim_if;
   logic [dpc_pkg::CODE_W-1:0] code;
   logic coding_sel;
   logic signed [dpc_pkg::OFS_W-1:0] offset;
   logic signed [dpc_pkg::FG_W-1:0] fine_gain;
   logic signed [dpc_pkg::GND_W-1:0] gnd_diff;
   logic gnd_en;
   logic [dpc_pkg::LEVEL_W-1:0] level;

   modport ctrl (output code, coding_sel, offset, fine_gain, gnd_diff, gnd_en, input level);
   modport trim (input code, coding_sel, offset, fine_gain, gnd_diff, gnd_en, output level);
endinterface
`default_nettype wire

/* File: hw/dpc_trim.sv */
// Purpose: Per-channel digital offset, fine gain and local ground correction
// Assumes: Purely combinational, registered by the caller
// Notes: Result saturates at the ends of the offset-binary range
`timescale 1ns/1ns
`default_nettype none
module dpc_trim (
   dpc_trim_if.trim t
);
   logic signed [dpc_pkg::CODE_W-1:0] centered;
   logic signed [dpc_pkg::CODE_W+dpc_pkg::FG_W-1:0] gprod;
   logic signed [dpc_pkg::LEVEL_W+1:0] sum;

   always_comb begin
      // Both codings mapped to a value centered on bipolar zero
      centered = t.coding_sel ? {~t.code[dpc_pkg::CODE_W-1], t.code[dpc_pkg::CODE_W-2:0]}
                              : t.code;
      // Half a step at each full-scale point, in eighth LSBs
      gprod = centered * t.fine_gain;
      sum = ((dpc_pkg::LEVEL_W+2)'(centered) <<< dpc_pkg::FRAC_W)
            + (dpc_pkg::LEVEL_W+2)'(gprod >>> dpc_pkg::GAIN_SHIFT)
            + (dpc_pkg::LEVEL_W+2)'(t.offset);
      if (t.gnd_en) begin
         sum = sum + (dpc_pkg::LEVEL_W+2)'(t.gnd_diff);
      end
      // Clip instead of wrapping, a wrap would swing the output rail to rail
      if (sum[dpc_pkg::LEVEL_W+1] && !sum[dpc_pkg::LEVEL_W-1]) begin
         t.level = '0;
      end else if (!sum[dpc_pkg::LEVEL_W+1] && sum[dpc_pkg::LEVEL_W-1]) begin
         t.level = '1;
      end else begin
         t.level = {~sum[dpc_pkg::LEVEL_W-1], sum[dpc_pkg::LEVEL_W-2:0]};
      end
   end
endmodule // dpc_trim
`default_nettype wire

/* File: hw/dpc_output_ctrl.sv */
// Purpose: Output clamp sequencing, power-on loading, trims and GP port of a quad DAC
// Assumes: Frame decoder on CLK delivers completed writes; pins are asynchronous
// Notes: Gate outputs drive the analog transmission gates, high means closed
`timescale 1ns/1ns
`default_nettype none
module dpc_output_ctrl #(
   parameter int NUM_CH = dpc_pkg::NUM_CH
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic SUPPLY_GOOD,
   input wire logic EXTERNAL_CLAMP_REQUEST_N,
   input wire logic CLEAR_TO_ZERO_CODE_N,
   input wire logic LOAD_OUTPUTS_STROBE_N,
   input wire logic CODING_SELECT,
   input wire logic WR_VALID,
   input wire logic [dpc_pkg::REG_W-1:0] WR_REG,
   input wire logic [dpc_pkg::ADDR_W-1:0] WR_ADDR,
   input wire logic [dpc_pkg::CODE_W-1:0] WR_DATA,
   input wire logic LOCAL_GROUND_ADJ_EN,
   input wire logic [NUM_CH-1:0][dpc_pkg::GND_W-1:0] CHANNEL_LOCAL_GROUND_DIFF,
   input wire logic [1:0] GP_DIR_OUT,
   input wire logic [1:0] GP_OUT_VALUE,
   input wire logic GP_PORT_BIT0_I,
   input wire logic GP_PORT_BIT1_I,
   output logic GP_PORT_BIT0_O,
   output logic GP_PORT_BIT0_OE_N,
   output logic GP_PORT_BIT1_O,
   output logic GP_PORT_BIT1_OE_N,
   output logic [1:0] GP_READ_LEVELS,
   output logic SUPPLY_MONITOR_OUT_N,
   output logic [NUM_CH-1:0] AMP_TO_PIN_GATE,
   output logic [NUM_CH-1:0] PIN_CLAMP_GATE,
   output logic [NUM_CH-1:0][dpc_pkg::CG_W-1:0] RANGE_SEL,
   output logic [NUM_CH-1:0][dpc_pkg::LEVEL_W-1:0] DAC_LEVEL
);
   // Channel field of an address is two bits, so four channels at most
   if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_num_ch
      $error("NUM_CH must lie between 1 and 4");
   end

   localparam int PIN_N = 7;
   localparam int P_SUP = 0;
   localparam int P_EXT = 1;
   localparam int P_CLR = 2;
   localparam int P_LD = 3;
   localparam int P_COD = 4;
   localparam int P_GP0 = 5;
   localparam int P_GP1 = 6;
   // Supply reads bad and active-low pins read inactive until synced
   localparam logic [PIN_N-1:0] PIN_RESET = 7'h0E;

   // Address bit two writes every channel at once
   function automatic logic ch_hit(input logic [dpc_pkg::ADDR_W-1:0] addr, input int ch);
      ch_hit = addr[dpc_pkg::ADDR_BCAST_BIT] || (int'(addr[1:0]) == ch);
   endfunction

   logic [PIN_N-1:0] pin_meta_ff;
   logic [PIN_N-1:0] pin_sync_ff;
   logic sup_ok;
   logic ext_clamp_n;
   logic clr_n;
   logic ld_n;
   dpc_pkg::dpc_state_t state_ff;
   dpc_pkg::dpc_state_t nxt_state;
   logic [dpc_pkg::STABLE_CNT_W-1:0] stable_cnt_ff;
   logic stable_done;
   logic strap_zero;
   logic strap_load;
   logic data_write;
   logic [NUM_CH-1:0][dpc_pkg::CODE_W-1:0] input_reg_ff;
   logic [NUM_CH-1:0][dpc_pkg::CODE_W-1:0] dac_reg_ff;
   logic [NUM_CH-1:0][dpc_pkg::OFS_W-1:0] offset_ff;
   logic [NUM_CH-1:0][dpc_pkg::FG_W-1:0] fine_ff;
   logic [NUM_CH-1:0][dpc_pkg::CG_W-1:0] coarse_ff;
   logic [NUM_CH-1:0][dpc_pkg::LEVEL_W-1:0] level;

   // Two-stage synchroniser for every pin input
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pin_meta_ff <= PIN_RESET;
         pin_sync_ff <= PIN_RESET;
      end else begin
         pin_meta_ff <= {GP_PORT_BIT1_I, GP_PORT_BIT0_I, CODING_SELECT, LOAD_OUTPUTS_STROBE_N,
                         CLEAR_TO_ZERO_CODE_N, EXTERNAL_CLAMP_REQUEST_N, SUPPLY_GOOD};
         pin_sync_ff <= pin_meta_ff;
      end
   end

   assign sup_ok = pin_sync_ff[P_SUP];
   assign ext_clamp_n = pin_sync_ff[P_EXT];
   assign clr_n = pin_sync_ff[P_CLR];
   assign ld_n = pin_sync_ff[P_LD];
   assign stable_done = (stable_cnt_ff == dpc_pkg::STABLE_CNT_W'(dpc_pkg::STABLE_CYCLES - 1));
   assign strap_zero = !clr_n || !ld_n;
   // Straps act only once, on the last settling cycle of power-up
   assign strap_load = (state_ff == dpc_pkg::ST_POWERUP) && stable_done && strap_zero;
   assign data_write = WR_VALID && (WR_REG == dpc_pkg::REG_DATA);

   // Supply must read good without a break before the straps are taken
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         stable_cnt_ff <= '0;
      end else if (!sup_ok || state_ff != dpc_pkg::ST_POWERUP) begin
         stable_cnt_ff <= '0;
      end else if (!stable_done) begin
         stable_cnt_ff <= stable_cnt_ff + 1'b1;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         dpc_pkg::ST_POWERUP: begin
            if (sup_ok && stable_done) begin
               // Both straps high leaves the outputs clamped
               nxt_state = strap_zero ? dpc_pkg::ST_ACTIVE : dpc_pkg::ST_WAIT_WRITE;
            end
         end
         dpc_pkg::ST_WAIT_WRITE: begin
            // A write under an active clamp request is kept but does not release
            if (data_write && ext_clamp_n) begin
               nxt_state = dpc_pkg::ST_ACTIVE;
            end
         end
         dpc_pkg::ST_ACTIVE: begin
            if (!ext_clamp_n) begin
               nxt_state = dpc_pkg::ST_WAIT_WRITE;
            end
         end
         default: nxt_state = dpc_pkg::ST_POWERUP;
      endcase
      // A failing supply overrides everything and restarts power-up
      if (!sup_ok) begin
         nxt_state = dpc_pkg::ST_POWERUP;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_ff <= dpc_pkg::ST_POWERUP;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Gates follow the next state so they switch with it, not a cycle later
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         AMP_TO_PIN_GATE <= '0;
         PIN_CLAMP_GATE <= '1;
      end else begin
         AMP_TO_PIN_GATE <= {NUM_CH{nxt_state == dpc_pkg::ST_ACTIVE && ext_clamp_n}};
         PIN_CLAMP_GATE <= {NUM_CH{nxt_state != dpc_pkg::ST_ACTIVE || !ext_clamp_n}};
      end
   end

   // Monitor follows the synced detector, so it lags the pin by three edges
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         SUPPLY_MONITOR_OUT_N <= 1'b0;
      end else begin
         SUPPLY_MONITOR_OUT_N <= sup_ok;
      end
   end

   // Input registers hold written words; the DAC registers feed the outputs
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         input_reg_ff <= '0;
      end else begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            if (strap_load) begin
               input_reg_ff[ch] <= dpc_pkg::ZERO_CODE;
            end else if (data_write && ch_hit(WR_ADDR, ch)) begin
               input_reg_ff[ch] <= WR_DATA;
            end
         end
      end
   end

   // Strobe held low updates on every write; the releasing write also updates
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         dac_reg_ff <= '0;
      end else begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            if (strap_load) begin
               dac_reg_ff[ch] <= dpc_pkg::ZERO_CODE;
            end else if (data_write && ch_hit(WR_ADDR, ch)
                         && (!ld_n || state_ff == dpc_pkg::ST_WAIT_WRITE)) begin
               dac_reg_ff[ch] <= WR_DATA;
            end else if (!ld_n && state_ff == dpc_pkg::ST_ACTIVE) begin
               dac_reg_ff[ch] <= input_reg_ff[ch];
            end
         end
      end
   end

   // Trim registers take effect at once; illegal range code is ignored
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         coarse_ff <= {NUM_CH{dpc_pkg::CG_RESET}};
      end else begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            if (WR_VALID && WR_REG == dpc_pkg::REG_COARSE && ch_hit(WR_ADDR, ch)
                && WR_DATA[dpc_pkg::CG_W-1:0] != dpc_pkg::CG_ILLEGAL) begin
               coarse_ff[ch] <= WR_DATA[dpc_pkg::CG_W-1:0];
            end
         end
      end
   end

   // Every fine gain and offset code is legal, so no filter here
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         fine_ff <= {NUM_CH{dpc_pkg::FG_RESET}};
      end else begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            if (WR_VALID && WR_REG == dpc_pkg::REG_FINE && ch_hit(WR_ADDR, ch)) begin
               fine_ff[ch] <= WR_DATA[dpc_pkg::FG_W-1:0];
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         offset_ff <= {NUM_CH{dpc_pkg::OFS_RESET}};
      end else begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            if (WR_VALID && WR_REG == dpc_pkg::REG_OFFSET && ch_hit(WR_ADDR, ch)) begin
               offset_ff[ch] <= WR_DATA[dpc_pkg::OFS_W-1:0];
            end
         end
      end
   end

   // One trim datapath per channel
   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      dpc_trim_if tif ();
      assign tif.code = dac_reg_ff[g];
      assign tif.coding_sel = pin_sync_ff[P_COD];
      assign tif.offset = offset_ff[g];
      assign tif.fine_gain = fine_ff[g];
      assign tif.gnd_diff = CHANNEL_LOCAL_GROUND_DIFF[g];
      assign tif.gnd_en = LOCAL_GROUND_ADJ_EN;
      assign level[g] = tif.level;
      dpc_trim u_trim (
         .t(tif)
      );
   end

   // Registered so the converter never sees the trim adders settle
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         DAC_LEVEL <= '0;
         RANGE_SEL <= {NUM_CH{dpc_pkg::CG_RESET}};
      end else begin
         DAC_LEVEL <= level;
         RANGE_SEL <= coarse_ff;
      end
   end

   // General-purpose port; pin levels read back whatever the direction
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         GP_PORT_BIT0_O <= 1'b0;
         GP_PORT_BIT1_O <= 1'b0;
         GP_PORT_BIT0_OE_N <= 1'b1;
         GP_PORT_BIT1_OE_N <= 1'b1;
         GP_READ_LEVELS <= 2'h0;
      end else begin
         GP_PORT_BIT0_O <= GP_OUT_VALUE[0];
         GP_PORT_BIT1_O <= GP_OUT_VALUE[1];
         GP_PORT_BIT0_OE_N <= !GP_DIR_OUT[0];
         GP_PORT_BIT1_OE_N <= !GP_DIR_OUT[1];
         GP_READ_LEVELS <= {pin_sync_ff[P_GP1], pin_sync_ff[P_GP0]};
      end
   end
endmodule // dpc_output_ctrl
`default_nettype wire

/* File: bench/dpc_output_ctrl_properties.sv */
// Purpose: Port-level checks of clamp sequencing, coarse range codes and GP port
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Pins pass two sync stages, so supply and clamp-request checks wait five cycles
`timescale 1ns/1ns
`default_nettype none
module dpc_output_ctrl_checker #(
   parameter int NUM_CH = dpc_pkg::NUM_CH
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic SUPPLY_GOOD,
   input wire logic EXTERNAL_CLAMP_REQUEST_N,
   input wire logic CLEAR_TO_ZERO_CODE_N,
   input wire logic LOAD_OUTPUTS_STROBE_N,
   input wire logic WR_VALID,
   input wire logic [dpc_pkg::REG_W-1:0] WR_REG,
   input wire logic [dpc_pkg::ADDR_W-1:0] WR_ADDR,
   input wire logic [dpc_pkg::CODE_W-1:0] WR_DATA,
   input wire logic [1:0] GP_DIR_OUT,
   input wire logic [1:0] GP_OUT_VALUE,
   input wire logic GP_PORT_BIT0_I,
   input wire logic GP_PORT_BIT1_I,
   input wire logic GP_PORT_BIT0_O,
   input wire logic GP_PORT_BIT0_OE_N,
   input wire logic GP_PORT_BIT1_O,
   input wire logic GP_PORT_BIT1_OE_N,
   input wire logic [1:0] GP_READ_LEVELS,
   input wire logic SUPPLY_MONITOR_OUT_N,
   input wire logic [NUM_CH-1:0] AMP_TO_PIN_GATE,
   input wire logic [NUM_CH-1:0] PIN_CLAMP_GATE,
   input wire logic [NUM_CH-1:0][dpc_pkg::CG_W-1:0] RANGE_SEL
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   logic [7:0] ok_cnt_ff;
   logic [2:0] up_cnt_ff;
   logic data_wr;
   assign data_wr = WR_VALID && WR_REG == dpc_pkg::REG_DATA;
   // Saturates so a long run never wraps into a false settling window
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) ok_cnt_ff <= 8'h00;
      else if (!SUPPLY_GOOD || !EXTERNAL_CLAMP_REQUEST_N) ok_cnt_ff <= 8'h00;
      else if (ok_cnt_ff != 8'hFF) ok_cnt_ff <= ok_cnt_ff + 8'h01;
   end
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) up_cnt_ff <= 3'h0;
      else if (up_cnt_ff != 3'h7) up_cnt_ff <= up_cnt_ff + 3'h1;
   end
   sequence s_sup_low; !SUPPLY_GOOD [*5]; endsequence
   sequence s_sup_high; SUPPLY_GOOD [*5]; endsequence
   sequence s_bad_cg;
      WR_VALID && WR_REG == dpc_pkg::REG_COARSE && WR_DATA[1:0] == 2'h3 ##1 !WR_VALID;
   endsequence
   property p_gate_pair;
      PIN_CLAMP_GATE == ~AMP_TO_PIN_GATE && (&AMP_TO_PIN_GATE || !(|AMP_TO_PIN_GATE));
   endproperty
   property p_mon_good; s_sup_high |-> SUPPLY_MONITOR_OUT_N; endproperty
   property p_sup_low; s_sup_low |-> !SUPPLY_MONITOR_OUT_N && !(|AMP_TO_PIN_GATE); endproperty
   property p_ext_clamp; !EXTERNAL_CLAMP_REQUEST_N [*5] |-> &PIN_CLAMP_GATE; endproperty
   property p_need_write;
      $rose(AMP_TO_PIN_GATE[0]) && CLEAR_TO_ZERO_CODE_N && LOAD_OUTPUTS_STROBE_N
         |-> $past(data_wr) || $past(data_wr, 2);
   endproperty
   property p_write_opens; ok_cnt_ff > 8'h8C && data_wr |-> ##[1:2] &AMP_TO_PIN_GATE; endproperty
   property p_range;
      WR_VALID && WR_REG == dpc_pkg::REG_COARSE && !WR_ADDR[2] && WR_DATA[1:0] != 2'h3
         |-> ##2 RANGE_SEL[$past(WR_ADDR[1:0], 2)] == $past(WR_DATA[1:0], 2);
   endproperty
   property p_cg_keep; s_bad_cg |-> ##1 $stable(RANGE_SEL); endproperty
   property p_gp_drive;
      $past(RESETN) |-> {GP_PORT_BIT1_OE_N, GP_PORT_BIT0_OE_N} == ~$past(GP_DIR_OUT)
         && (GP_PORT_BIT0_OE_N || GP_PORT_BIT0_O == $past(GP_OUT_VALUE[0]))
         && (GP_PORT_BIT1_OE_N || GP_PORT_BIT1_O == $past(GP_OUT_VALUE[1]));
   endproperty
   property p_readback;
      up_cnt_ff == 3'h7 |-> GP_READ_LEVELS == $past({GP_PORT_BIT1_I, GP_PORT_BIT0_I}, 3);
   endproperty
   a_gate_pair: assert property (p_gate_pair) else $error("gate pair mismatch");
   a_mon_good: assert property (p_mon_good) else $error("monitor low on good supply");
   a_sup_low: assert property (p_sup_low) else $error("no clamp on low supply");
   a_ext_clamp: assert property (p_ext_clamp) else $error("no clamp on request");
   a_need_write: assert property (p_need_write) else $error("opened without write");
   a_write_opens: assert property (p_write_opens) else $error("write did not open");
   a_range: assert property (p_range) else $error("range code not applied");
   a_cg_keep: assert property (p_cg_keep) else $error("illegal range code taken");
   a_gp_drive: assert property (p_gp_drive) else $error("port drive mismatch");
   a_readback: assert property (p_readback) else $error("port readback mismatch");
endmodule // dpc_output_ctrl_checker
bind dpc_output_ctrl dpc_output_ctrl_checker #(.NUM_CH(NUM_CH)) i_chk (
   .CLK, .RESETN, .SUPPLY_GOOD, .EXTERNAL_CLAMP_REQUEST_N, .CLEAR_TO_ZERO_CODE_N,
   .LOAD_OUTPUTS_STROBE_N, .WR_VALID, .WR_REG, .WR_ADDR, .WR_DATA, .GP_DIR_OUT,
   .GP_OUT_VALUE, .GP_PORT_BIT0_I, .GP_PORT_BIT1_I, .GP_PORT_BIT0_O, .GP_PORT_BIT0_OE_N,
   .GP_PORT_BIT1_O, .GP_PORT_BIT1_OE_N, .GP_READ_LEVELS, .SUPPLY_MONITOR_OUT_N,
   .AMP_TO_PIN_GATE, .PIN_CLAMP_GATE, .RANGE_SEL
);
`default_nettype wire

/* File: bench/dpc_host_model.sv */
// Purpose: Host side: completed write frames and board levels on the port pins
// Assumes: Frames arrive as one-cycle strobes on the system clock
// Notes: Write fields are scrambled once the strobe is gone
`timescale 1ns/1ns
`default_nettype none
module dpc_host_model (
   input wire logic CLK,
   input wire logic [1:0] EXT,
   input wire logic [1:0] OE_N,
   input wire logic [1:0] DRV,
   output logic [1:0] PIN,
   output logic WR_VALID,
   output logic [dpc_pkg::REG_W-1:0] WR_REG,
   output logic [dpc_pkg::ADDR_W-1:0] WR_ADDR,
   output logic [dpc_pkg::CODE_W-1:0] WR_DATA
);
   // Design drive wins while enabled, else the board level shows
   assign PIN = (~OE_N & DRV) | (OE_N & EXT);
   initial begin
      WR_VALID = 1'b0;
      WR_REG = '0;
      WR_ADDR = '0;
      WR_DATA = '0;
   end
   task automatic send(input logic [2:0] r, input logic [2:0] a, input logic [15:0] d);
      @(posedge CLK);
      #1;
      WR_VALID = 1'b1;
      WR_REG = r;
      WR_ADDR = a;
      WR_DATA = d;
      @(posedge CLK);
      #1;
      WR_VALID = 1'b0;
      WR_REG = ~r;
      WR_ADDR = ~a;
      WR_DATA = ~d;
   endtask
endmodule // dpc_host_model
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: Self-checking bench for the output control block
// Assumes: Host model issues frames, bench drives straps, supply and pins
// Notes: Expected levels come from an integer model of the trims
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int N = dpc_pkg::NUM_CH;
   logic clk, resetn, sup, ext_n, clr_n, load_outputs_strobe_n_n, coding, gnd_en, wr_valid, smon;
   logic [1:0] dir, val, ext, pin, rd;
   wire [1:0] oe_n, drv;
   logic [dpc_pkg::REG_W-1:0] wr_reg;
   logic [dpc_pkg::ADDR_W-1:0] wr_addr;
   logic [dpc_pkg::CODE_W-1:0] wr_data;
   logic [N-1:0][dpc_pkg::GND_W-1:0] gd;
   logic [N-1:0] amp, clamp;
   logic [N-1:0][dpc_pkg::CG_W-1:0] rsel;
   logic [N-1:0][dpc_pkg::LEVEL_W-1:0] lvl;
   int n_mismatch, check_count;
   int inp[N], dac[N], cg[N], fg[N], of[N];
   logic [2:0] regs[4] = '{dpc_pkg::REG_DATA, dpc_pkg::REG_COARSE, dpc_pkg::REG_FINE,
      dpc_pkg::REG_OFFSET};
   dpc_output_ctrl #(.NUM_CH(N)) i_dpc_output_ctrl (
      .CLK(clk), .RESETN(resetn), .SUPPLY_GOOD(sup), .EXTERNAL_CLAMP_REQUEST_N(ext_n),
      .CLEAR_TO_ZERO_CODE_N(clr_n), .LOAD_OUTPUTS_STROBE_N(load_outputs_strobe_n_n), .CODING_SELECT(coding),
      .WR_VALID(wr_valid), .WR_REG(wr_reg), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
      .LOCAL_GROUND_ADJ_EN(gnd_en), .CHANNEL_LOCAL_GROUND_DIFF(gd), .GP_DIR_OUT(dir),
      .GP_OUT_VALUE(val), .GP_PORT_BIT0_I(pin[0]), .GP_PORT_BIT1_I(pin[1]),
      .GP_PORT_BIT0_O(drv[0]), .GP_PORT_BIT0_OE_N(oe_n[0]), .GP_PORT_BIT1_O(drv[1]),
      .GP_PORT_BIT1_OE_N(oe_n[1]), .GP_READ_LEVELS(rd), .SUPPLY_MONITOR_OUT_N(smon),
      .AMP_TO_PIN_GATE(amp), .PIN_CLAMP_GATE(clamp), .RANGE_SEL(rsel), .DAC_LEVEL(lvl));
   dpc_host_model i_dpc_host_model (.CLK(clk), .EXT(ext), .OE_N(oe_n), .DRV(drv),
      .PIN(pin), .WR_VALID(wr_valid), .WR_REG(wr_reg), .WR_ADDR(wr_addr), .WR_DATA(wr_data));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic tally(input logic bad, input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (bad) begin
         n_mismatch++;
         $display("Error at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask
   task automatic cmp_level(input logic [dpc_pkg::LEVEL_W-1:0] g, input int e);
      tally(g !== e[dpc_pkg::LEVEL_W-1:0], 32'(g), e);
   endtask
   task automatic cmp_sig(input logic [15:0] g, input logic [15:0] e);
      tally(g !== e, 32'(g), 32'(e));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic gates(input logic open);
      cmp_sig(16'({amp, clamp}), open ? 16'({{N{1'b1}}, {N{1'b0}}}) : 16'({N{1'b1}}));
   endtask
   // Eighth-LSB level with fine gain, offset and ground terms, clipped
   function automatic int exp_lvl(int ch);
      int c, s;
      c = coding ? dac[ch] - 32768 : int'($signed(16'(dac[ch])));
      s = c * 8 + ((c * fg[ch]) >>> 13) + of[ch] + 262144;
      s = s + (gnd_en ? int'($signed(gd[ch])) : 0);
      return s < 0 ? 0 : (s > 524287 ? 524287 : s);
   endfunction
   task automatic chk_all();
      for (int ch = 0; ch < N; ch++) begin
         cmp_level(lvl[ch], exp_lvl(ch));
         cmp_sig(16'(rsel[ch]), 16'(cg[ch]));
      end
   endtask
   task automatic wr(input logic [2:0] r, input logic [2:0] a, input logic [15:0] d);
      i_dpc_host_model.send(r, a, d);
      for (int ch = 0; ch < N; ch++) begin
         if (a[2] || a[1:0] == ch) begin
            case (r)
               dpc_pkg::REG_DATA: inp[ch] = d;
               dpc_pkg::REG_COARSE: cg[ch] = d[1:0] == 2'h3 ? cg[ch] : d[1:0];
               dpc_pkg::REG_FINE: fg[ch] = $signed(d[5:0]);
               default: of[ch] = $signed(d[7:0]);
            endcase
            if (!load_outputs_strobe_n_n) dac[ch] = inp[ch];
         end
      end
   endtask
   task automatic rel_write(input logic [15:0] d);
      wr(dpc_pkg::REG_DATA, 3'h4, d);
      cyc(4);
      foreach (dac[ch]) dac[ch] = inp[ch];
   endtask
   // Strap load clears both register ranks
   task automatic zero_model();
      foreach (dac[ch]) begin
         dac[ch] = 0;
         inp[ch] = 0;
      end
   endtask
   task automatic power_up(input logic c_n, input logic l_n, input logic cod);
      sup = 1'b0;
      cyc(8);
      cmp_sig(16'(smon), 16'h0000);
      gates(1'b0);
      {clr_n, load_outputs_strobe_n_n, coding} = {c_n, l_n, cod};
      sup = 1'b1;
      cyc(100);
      gates(1'b0);
      cmp_sig(16'(smon), 16'h0001);
      cyc(40);
   endtask
   initial begin
      #200000;
      n_mismatch++;
      results();
   end
   initial begin
      {resetn, sup, ext_n, clr_n, load_outputs_strobe_n_n, coding, gnd_en} = 7'b0011100;
      {dir, val, ext} = '0;
      gd = '0;
      ext = 2'($urandom(32'h1224F150));
      cyc(6);
      resetn = 1'b1;
      cyc(2);
      gates(1'b0);
      power_up(1'b1, 1'b1, 1'b0);
      gates(1'b0);
      rel_write(16'($urandom));
      gates(1'b1);
      chk_all();
      ext_n = 1'b0;
      cyc(6);
      gates(1'b0);
      ext_n = 1'b1;
      cyc(6);
      gates(1'b0);
      rel_write(16'($urandom) | 16'h0001);
      gates(1'b1);
      power_up(1'b0, 1'b1, 1'b0);
      zero_model();
      gates(1'b1);
      chk_all();
      wr(dpc_pkg::REG_DATA, 3'h4, 16'($urandom) | 16'h0001);
      cyc(4);
      chk_all();
      power_up(1'b1, 1'b0, 1'b1);
      zero_model();
      gates(1'b1);
      chk_all();
      wr(dpc_pkg::REG_COARSE, 3'h4, 16'h0003);
      cyc(6);
      chk_all();
      for (int i = 0; i < 48; i++) begin
         {coding, gnd_en} = 2'($urandom);
         gd = $urandom;
         wr(regs[i % 4], 3'($urandom), 16'($urandom));
         cyc(6);
         chk_all();
      end
      for (int i = 0; i < 16; i++) begin
         {dir, val} = 4'(i);
         ext = 2'($urandom);
         cyc(5);
         cmp_sig(16'(oe_n), 16'({~dir}));
         cmp_sig(16'(pin), 16'((dir & val) | (~dir & ext)));
         cmp_sig(16'(rd), 16'((dir & val) | (~dir & ext)));
      end
      results();
   end
endmodule // tb
`default_nettype wire
